/* File: src/bra_adder.sv */
// Accumulator adder: 16-bit BCD, 32-bit BCD and single-precision real adds.
// Assumes a classic Wishbone master on the one clock, supplying fetched operands.
//
// Function
// - Four-digit BCD add of accumulator low half and a memory word into accumulator.
// - Eight-digit BCD add of whole accumulator and a 32-bit operand.
// - Eight-digit operand comes from two memory words or an immediate constant.
// - Zero flag set whenever the accumulator result is zero.
// - Narrow carry flag set on carry out of the four-digit add.
// - Wide carry flag set on carry out of the eight-digit add.
// - Negative flag set whenever the accumulator value is negative.
// - Invalid operand flag set when a BCD operand holds an illegal digit.
// - Real add of accumulator and a 32-bit real operand, result in accumulator.
// - Reals use sign bit, 8-bit biased exponent, 23-bit fraction layout.
// - Invalid pointer flag set when a real add pointer names no valid memory.
// - Invalid float flag set when the accumulator is not a valid real.
// - Sign error flag set when a signed add yields a wrong sign bit.
// - Underflow flag set when a real sum is too small to represent.
// - Invalid operand flag set when a real add meets a non-real operand.
// - Each flag holds until the next operation that writes that flag.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module bra_adder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Status
    output bra_pkg::bra_flags_t flags_o,
    output logic busy_o,
    output logic irq_o
);
    import bra_pkg::*;

    typedef enum logic [1:0] {
        BRA_ST_IDLE,
        BRA_ST_BCD,
        BRA_ST_FP
    } bra_state_t;

    // =========================================================
    // Helpers
    // Digit-wise decimal add over all eight digits; bit 32 is the carry out
    function automatic logic [32:0] bcd_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] r;
        logic c;
        logic [4:0] d;
        r = '0;
        c = 1'b0;
        for (int i = 0; i < BRA_BCD_DIGITS; i++) begin
            d = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
            c = (d > {1'b0, BRA_BCD_MAX_DIGIT});
            r[4*i +: 4] = c ? 4'(d - 5'd10) : d[3:0];
        end
        r[32] = c;
        return r;
    endfunction

    function automatic logic bcd_bad(input logic [31:0] v);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < BRA_BCD_DIGITS; i++) begin
            bad = bad | (v[4*i +: 4] > BRA_BCD_MAX_DIGIT);
        end
        return bad;
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // =========================================================
    // State
    bra_state_t state_q, state_d;
    logic [31:0] acc_q, acc_d;
    logic [31:0] operand_q;
    bra_cmd_t cmd_q;
    bra_flags_t flags_q, flags_d;
    logic [BRA_IRQ_W-1:0] irq_stat_q, irq_mask_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [BRA_IRQ_W-1:0] irq_set;

    // =========================================================
    // Bus decode
    // Writes land on the edge that sees ack high, so the master's hold is honoured
    wire req = cyc_i && stb_i;
    wire wr_fire = req && we_i && ack_q;
    wire hit_acc = (adr_i == BRA_ADDR_ACC);
    wire hit_opnd = (adr_i == BRA_ADDR_OPERAND);
    wire hit_cmd = (adr_i == BRA_ADDR_CMD);
    wire hit_flags = (adr_i == BRA_ADDR_FLAGS);
    wire hit_stat = (adr_i == BRA_ADDR_IRQ_STAT);
    wire hit_mask = (adr_i == BRA_ADDR_IRQ_MASK);
    wire idle = (state_q == BRA_ST_IDLE);
    wire [31:0] cmd_word = byte_merge(32'h0000_0000, dat_i, sel_i);
    wire bra_cmd_t cmd_new = bra_cmd_t'(cmd_word[$bits(bra_cmd_t)-1:0]);
    // A new command is taken only while idle; otherwise it is dropped silently
    wire cmd_go = wr_fire && hit_cmd && idle && (cmd_new.op != BRA_OP_NONE);
    wire [31:0] flags_word = {busy_o, {(31 - $bits(bra_flags_t)){1'b0}}, flags_q};
    wire [31:0] rd_mux = hit_acc ? acc_q :
                         hit_opnd ? operand_q :
                         hit_cmd ? {{(32 - $bits(bra_cmd_t)){1'b0}}, cmd_q} :
                         hit_flags ? flags_word :
                         hit_stat ? {{(32 - BRA_IRQ_W){1'b0}}, irq_stat_q} :
                         hit_mask ? {{(32 - BRA_IRQ_W){1'b0}}, irq_mask_q} :
                         32'h0000_0000;

    // =========================================================
    // Operation decode
    wire refuse_imm = (cmd_new.op == BRA_OP_ADD16) && (cmd_new.src == BRA_SRC_IMMEDIATE);
    wire bad_ptr = (cmd_new.op == BRA_OP_ADDREAL) && (cmd_new.src == BRA_SRC_POINTER) && !cmd_new.ptr_ok;
    wire [31:0] acc_lo = {16'h0000, acc_q[BRA_HALF_W-1:0]};
    wire [31:0] opnd_lo = {16'h0000, operand_q[BRA_HALF_W-1:0]};
    wire is_add16 = (cmd_q.op == BRA_OP_ADD16);
    wire [31:0] bcd_a = is_add16 ? acc_lo : acc_q;
    wire [31:0] bcd_b = is_add16 ? opnd_lo : operand_q;
    wire [32:0] bcd_sum = bcd_add(bcd_a, bcd_b);
    wire bcd_invalid = bcd_bad(bcd_a) || bcd_bad(bcd_b);
    wire fp_valid;
    bra_fp_res_t fp_res;

    bra_fp_adder u_fp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(cmd_go && (cmd_new.op == BRA_OP_ADDREAL) && !bad_ptr),
        .a_i(acc_q),
        .b_i(operand_q),
        .valid_o(fp_valid),
        .res_o(fp_res)
    );

    // =========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        flags_d = flags_q;
        irq_set = '0;
        unique case (state_q)
            BRA_ST_IDLE: begin
                if (cmd_go) begin
                    if (refuse_imm) begin
                        irq_set[BRA_IRQ_ERR_BIT] = 1'b1;
                        irq_set[BRA_IRQ_DONE_BIT] = 1'b1;
                    end else if (bad_ptr) begin
                        flags_d.invalid_pointer_flag = 1'b1;
                        irq_set[BRA_IRQ_ERR_BIT] = 1'b1;
                        irq_set[BRA_IRQ_DONE_BIT] = 1'b1;
                    end else if (cmd_new.op == BRA_OP_ADDREAL) begin
                        state_d = BRA_ST_FP;
                    end else begin
                        state_d = BRA_ST_BCD;
                    end
                end
            end
            BRA_ST_BCD: begin
                // Illegal digits leave the accumulator alone, raise the flag and the error interrupt, and clear the carry
                if (!bcd_invalid) begin
                    acc_d = is_add16 ? {16'h0000, bcd_sum[BRA_HALF_W-1:0]} : bcd_sum[31:0];
                end
                flags_d.zero_result_flag = (acc_d == 32'h0000_0000);
                flags_d.negative_result_flag = acc_d[31];
                flags_d.invalid_operand_flag = bcd_invalid;
                if (is_add16) begin
                    flags_d.narrow_carry_flag = !bcd_invalid && bcd_sum[BRA_HALF_W];
                end else begin
                    flags_d.wide_carry_flag = !bcd_invalid && bcd_sum[32];
                end
                irq_set[BRA_IRQ_DONE_BIT] = 1'b1;
                irq_set[BRA_IRQ_ERR_BIT] = bcd_invalid;
                state_d = BRA_ST_IDLE;
            end
            BRA_ST_FP: begin
                if (fp_valid) begin
                    if (!fp_res.bad_operand) begin
                        acc_d = fp_res.sum;
                    end
                    flags_d.zero_result_flag = (acc_d[30:0] == 31'h0000_0000);
                    flags_d.negative_result_flag = acc_d[31];
                    flags_d.invalid_pointer_flag = 1'b0;
                    flags_d.invalid_float_flag = (acc_d[30:23] == BRA_FP_EXP_MAX);
                    flags_d.sign_error_flag = fp_res.sign_err;
                    flags_d.float_underflow_flag = fp_res.underflow;
                    flags_d.invalid_operand_flag = fp_res.bad_operand;
                    irq_set[BRA_IRQ_DONE_BIT] = 1'b1;
                    irq_set[BRA_IRQ_ERR_BIT] = fp_res.bad_operand | fp_res.overflow | fp_res.underflow;
                    state_d = BRA_ST_IDLE;
                end
            end
            default: begin
                state_d = BRA_ST_IDLE;
            end
        endcase
        // Software may preload the accumulator, but only between operations
        if (wr_fire && hit_acc && idle) begin
            acc_d = byte_merge(acc_q, dat_i, sel_i);
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= BRA_ST_IDLE;
            acc_q <= BRA_ACC_RST;
            flags_q <= BRA_FLAGS_RST;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            operand_q <= 32'h0000_0000;
            cmd_q <= '0;
        end else begin
            if (wr_fire && hit_opnd && idle) begin
                operand_q <= byte_merge(operand_q, dat_i, sel_i);
            end
            if (cmd_go) begin
                cmd_q <= cmd_new;
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= BRA_IRQ_MASK_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr_fire && hit_stat) ? dat_i[BRA_IRQ_W-1:0] : '0)) | irq_set;
            if (wr_fire && hit_mask) begin
                irq_mask_q <= dat_i[BRA_IRQ_W-1:0];
            end
        end
    end

    // Answer one cycle after the request; unmapped reads give zero, writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && !ack_q;
            if (req && !ack_q && !we_i) begin
                dat_q <= rd_mux;
            end
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign flags_o = flags_q;
    assign busy_o = !idle;
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_BCD16_SUM: assert property (state_q == BRA_ST_BCD && is_add16 && !bcd_invalid |=>
        acc_q == {16'h0000, $past(bcd_sum[15:0])}) else $error("four-digit sum not stored");
    AST_BCD32_SUM: assert property (state_q == BRA_ST_BCD && !is_add16 && !bcd_invalid |=>
        acc_q == $past(bcd_sum[31:0])) else $error("eight-digit sum not stored");
    AST_ZERO_FLAG: assert property ((state_q == BRA_ST_BCD) |=>
        flags_q.zero_result_flag == (acc_q == 32'h0000_0000)) else $error("zero flag wrong");
    AST_CARRY16: assert property (state_q == BRA_ST_BCD && is_add16 |=>
        flags_q.narrow_carry_flag == ($past(bcd_sum[16]) && !$past(bcd_invalid)) &&
        $stable(flags_q.wide_carry_flag)) else $error("narrow carry wrong");
    AST_CARRY32: assert property (state_q == BRA_ST_BCD && !is_add16 |=>
        flags_q.wide_carry_flag == ($past(bcd_sum[32]) && !$past(bcd_invalid))) else $error("wide carry wrong");
    // A bad pointer holds the negative flag, so only completed adds are judged here
    AST_NEG_FLAG: assert property (state_q == BRA_ST_BCD || (state_q == BRA_ST_FP && fp_valid) |=>
        flags_q.negative_result_flag == acc_q[31]) else $error("negative flag wrong");
    AST_BAD_DIGIT: assert property (state_q == BRA_ST_BCD && bcd_invalid |=>
        flags_q.invalid_operand_flag && $stable(acc_q)) else $error("illegal digit missed");
    AST_FP_DONE: assert property (cmd_go && cmd_new.op == BRA_OP_ADDREAL && !bad_ptr |->
        ##[1:3] (irq_stat_q[BRA_IRQ_DONE_BIT] && idle)) else $error("real add never finished");
    AST_BAD_PTR: assert property (cmd_go && bad_ptr |=>
        flags_q.invalid_pointer_flag && $stable(acc_q) && idle) else $error("bad pointer not flagged");
    AST_INV_FLOAT: assert property (state_q == BRA_ST_FP && fp_valid && fp_res.overflow &&
        !fp_res.bad_operand |=> flags_q.invalid_float_flag && acc_q[30:23] == BRA_FP_EXP_MAX)
        else $error("float flag wrong");
    AST_UNDERFLOW: assert property (state_q == BRA_ST_FP && fp_valid && fp_res.underflow |=>
        flags_q.float_underflow_flag && flags_q.zero_result_flag) else $error("underflow not flagged");
    AST_FLAG_HOLD: assert property (idle && !cmd_go |=> $stable(flags_q)) else $error("flag moved idle");
    AST_ACC_HOLD: assert property (cmd_go || (state_q == BRA_ST_FP && !fp_valid) |=>
        $stable(acc_q)) else $error("acc early");
    AST_IRQ_LEVEL: assert property (irq_o == |(irq_stat_q & irq_mask_q)) else $error("interrupt level wrong");
    AST_ADD16_UPPER: assert property (state_q == BRA_ST_BCD && is_add16 && !bcd_invalid |=>
        acc_q[31:16] == 16'h0000) else $error("upper half not cleared");
    AST_REFUSE_IMM: assert property (cmd_go && refuse_imm |=>
        $stable(acc_q) && $stable(flags_q) && idle) else $error("immediate four-digit add accepted");
    AST_BCD_KEEP: assert property (state_q == BRA_ST_BCD |=>
        $stable(flags_q.float_underflow_flag) && $stable(flags_q.invalid_float_flag) &&
        $stable(flags_q.sign_error_flag) && $stable(flags_q.invalid_pointer_flag)) else $error("real flag moved");
    AST_SET_WINS: assert property (irq_set[BRA_IRQ_DONE_BIT] |=> irq_stat_q[BRA_IRQ_DONE_BIT])
        else $error("done event lost");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");

    COV_BCD16_CARRY: cover property (state_q == BRA_ST_BCD && is_add16 && bcd_sum[16] && !bcd_invalid);
    COV_BCD32_CARRY: cover property (state_q == BRA_ST_BCD && !is_add16 && bcd_sum[32] && !bcd_invalid);
    COV_FP_UNDER: cover property (fp_valid && fp_res.underflow);
    COV_IRQ: cover property (irq_o ##1 !irq_o);
    COV_BAD_PTR: cover property (cmd_go && bad_ptr);
endmodule

/* File: src/bra_pkg.sv */
// Package for the decimal and real accumulator adder.
// Assumes a single clock domain and a classic Wishbone register slave.
package bra_pkg;

    // =========================================================
    // Register map, byte addresses of 32-bit words
    localparam logic [7:0] BRA_ADDR_ACC = 8'h00;
    localparam logic [7:0] BRA_ADDR_OPERAND = 8'h04;
    localparam logic [7:0] BRA_ADDR_CMD = 8'h08;
    localparam logic [7:0] BRA_ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] BRA_ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] BRA_ADDR_IRQ_MASK = 8'h14;

    // =========================================================
    // Field positions and reset values
    localparam int BRA_FLAGS_BUSY_BIT = 31;
    localparam int BRA_IRQ_W = 2;
    localparam int BRA_IRQ_DONE_BIT = 0;
    localparam int BRA_IRQ_ERR_BIT = 1;
    localparam logic [31:0] BRA_ACC_RST = 32'h0000_0000;
    localparam logic [1:0] BRA_IRQ_MASK_RST = 2'h0;

    // =========================================================
    // Number formats
    localparam int BRA_BCD_DIGITS = 8;
    localparam logic [3:0] BRA_BCD_MAX_DIGIT = 4'h9;
    localparam int BRA_HALF_W = 16;
    localparam int BRA_FP_EXP_W = 8;
    localparam int BRA_FP_FRAC_W = 23;
    localparam logic [7:0] BRA_FP_EXP_MAX = 8'hFF;
    localparam logic [4:0] BRA_FP_SHIFT_LIMIT = 5'h19;

    // =========================================================
    // Command encodings
    typedef enum logic [1:0] {
        BRA_OP_NONE = 2'h0,
        BRA_OP_ADD16 = 2'h1,
        BRA_OP_ADD32 = 2'h2,
        BRA_OP_ADDREAL = 2'h3
    } bra_op_t;

    typedef enum logic [1:0] {
        BRA_SRC_DIRECT = 2'h0,
        BRA_SRC_POINTER = 2'h1,
        BRA_SRC_IMMEDIATE = 2'h2,
        BRA_SRC_RSVD = 2'h3
    } bra_src_t;

    // Command word: [1:0] op, [3:2] source, [4] pointer designates valid memory
    typedef struct packed {
        logic ptr_ok;
        bra_src_t src;
        bra_op_t op;
    } bra_cmd_t;

    // Flags word, bit 0 upward: zero, carry16, carry32, negative, pointer,
    // float, sign error, underflow, operand
    typedef struct packed {
        logic invalid_operand_flag;
        logic float_underflow_flag;
        logic sign_error_flag;
        logic invalid_float_flag;
        logic invalid_pointer_flag;
        logic negative_result_flag;
        logic wide_carry_flag;
        logic narrow_carry_flag;
        logic zero_result_flag;
    } bra_flags_t;

    localparam bra_flags_t BRA_FLAGS_RST = 9'h000;

    // Real adder answer
    typedef struct packed {
        logic [31:0] sum;
        logic underflow;
        logic overflow;
        logic sign_err;
        logic bad_operand;
    } bra_fp_res_t;

endpackage

/* File: src/bra_fp_adder.sv */
// Single-precision real adder with a registered answer one cycle after start.
// Assumes operands are held stable in the start cycle; denormals flush to zero.
`timescale 1ns/1ns
module bra_fp_adder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request
    input wire logic start_i,
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    // Answer
    output logic valid_o,
    output bra_pkg::bra_fp_res_t res_o
);
    import bra_pkg::*;

    function automatic logic [4:0] lead_zeros(input logic [23:0] v);
        logic [4:0] n;
        n = 5'd24;
        for (int i = 0; i < 24; i++) begin
            if (v[i]) begin
                n = 5'(23 - i);
            end
        end
        return n;
    endfunction

    logic valid_q;
    bra_fp_res_t res_q;

    // =========================================================
    // Align, add and normalise
    wire swap = {a_i[30:23], a_i[22:0]} < {b_i[30:23], b_i[22:0]};
    wire [31:0] big = swap ? b_i : a_i;
    wire [31:0] lesser = swap ? a_i : b_i;
    wire [7:0] e_big = big[30:23];
    wire [7:0] e_small = lesser[30:23];
    wire [23:0] m_big = (e_big == 8'h00) ? 24'h00_0000 : {1'b1, big[22:0]};
    wire [23:0] m_small = (e_small == 8'h00) ? 24'h00_0000 : {1'b1, lesser[22:0]};
    wire [7:0] shift = e_big - e_small;
    wire [23:0] m_aligned = (shift >= {3'h0, BRA_FP_SHIFT_LIMIT}) ? 24'h00_0000 : (m_small >> shift);
    wire eff_sub = big[31] ^ lesser[31];
    wire [24:0] raw = eff_sub ? ({1'b0, m_big} - {1'b0, m_aligned}) : ({1'b0, m_big} + {1'b0, m_aligned});
    wire [4:0] lz = lead_zeros(raw[23:0]);
    wire [23:0] norm = raw[23:0] << lz;
    wire [23:0] mant = raw[24] ? raw[24:1] : norm;
    wire signed [9:0] exp_n = raw[24] ? $signed({2'b00, e_big}) + 10'sd1 : $signed({2'b00, e_big}) - $signed({5'h00, lz});
    wire res_zero = (raw == 25'h000_0000);
    wire under = !res_zero && (exp_n <= 10'sd0);
    wire over = !res_zero && (exp_n >= $signed({2'b00, BRA_FP_EXP_MAX}));
    wire bad_op = (a_i[30:23] == BRA_FP_EXP_MAX) || (b_i[30:23] == BRA_FP_EXP_MAX);
    // Same-sign operands can only show a wrong sign when the sum leaves the range
    wire sign_bad = !eff_sub && over;
    wire [31:0] packed_sum = (res_zero || under) ? 32'h0000_0000 :
                             over ? {big[31], BRA_FP_EXP_MAX, 23'h00_0000} :
                             {big[31], exp_n[7:0], mant[22:0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            res_q <= '0;
        end else begin
            valid_q <= start_i;
            if (start_i) begin
                res_q <= '{sum: packed_sum, underflow: under, overflow: over, sign_err: sign_bad,
                           bad_operand: bad_op};
            end
        end
    end

    assign valid_o = valid_q;
    assign res_o = res_q;
endmodule

/* File: testbench/bra_seq_model.sv */
// Sequencer model: classic Wishbone master that fetches operands and issues adds.
// Assumes the adder acks each request with a one-cycle pulse on the same clock.
`timescale 1ns/1ns
module bra_seq_model (
    // Clock
    input wire logic clk_i,
    // Wishbone master
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // ====================
    // One transfer; an immediate add16 goes out only when the bench asks for it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        ok = 1'b0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge clk_i);
            ok = ack_i;
        end
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released lines must not keep looking valid
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule

/* File: testbench/tb.sv */
// Bench for the accumulator adder: the sequencer model drives the bus, tasks judge.
// Assumes the package and the adder sources are compiled first.
`timescale 1ns/1ns
module tb;
    import bra_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, busy_o, irq_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd_q;
    bra_flags_t flags_o;
    logic busy_seen;
    int num_errors, compares;
    bra_adder i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .flags_o(flags_o), .busy_o(busy_o), .irq_o(irq_o));
    bra_seq_model i_seq (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i),
        .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ====================
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic [8:0] m, input logic [8:0] e);
        chk({23'h0, flags_o & m}, {23'h0, e});
    endtask
    // The interrupt line is looked at mid-cycle, after the last write has landed
    task automatic chk_irq(input logic e);
        @(negedge clk_i);
        chk({31'h0, irq_o}, {31'h0, e});
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        i_seq.xfer(w, a, d, rd_q, ok);
        if (!ok) begin
            num_errors++;
            end_sim();
        end
    endtask
    // Loads both operands, issues the command, polls busy, then checks the accumulator
    task automatic run(input logic [31:0] acc, opnd, cmd, exp);
        bus(1'b1, BRA_ADDR_ACC, acc);
        bus(1'b1, BRA_ADDR_OPERAND, opnd);
        bus(1'b1, BRA_ADDR_CMD, cmd);
        @(negedge clk_i);
        busy_seen = busy_o;
        rd_q = 32'hFFFF_FFFF;
        for (int i = 0; i < 8 && rd_q[BRA_FLAGS_BUSY_BIT]; i++) bus(1'b0, BRA_ADDR_FLAGS, 32'h0);
        if (rd_q[BRA_FLAGS_BUSY_BIT] !== 1'b0) begin
            num_errors++;
            end_sim();
        end
        bus(1'b0, BRA_ADDR_ACC, 32'h0);
        chk(rd_q, exp);
    endtask
    // ====================
    task automatic t_reset();
        chkf(9'h1FF, 9'h000);
        bus(1'b0, BRA_ADDR_ACC, 32'h0);
        chk(rd_q, BRA_ACC_RST);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd_q, 32'h0);
    endtask
    task automatic t_bcd();
        run(32'h9999_9999, 32'h0000_0001, 32'h0000_000A, 32'h0000_0000);
        chkf(9'h10F, 9'h005);
        chk({31'h0, busy_seen}, 32'h1);
        run(32'h0001_9999, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000);
        chkf(9'h00F, 9'h007);
        run(32'h1234_5678, 32'h1111_1111, 32'h0000_0002, 32'h2345_6789);
        chkf(9'h00F, 9'h002);
        run(32'h0000_1234, 32'h0000_4321, 32'h0000_0001, 32'h0000_5555);
        chkf(9'h00F, 9'h000);
        run(32'h0000_00A0, 32'h0000_0001, 32'h0000_0002, 32'h0000_00A0);
        chkf(9'h104, 9'h100);
    endtask
    // Operands other than the NaN of the fourth add stay within a 2^24 magnitude ratio of each other
    task automatic t_real();
        run(32'h40E0_0000, 32'h4170_0000, 32'h0000_0003, 32'h41B0_0000);
        chkf(9'h1F9, 9'h000);
        run(32'hC1B0_0000, 32'h40E0_0000, 32'h0000_0017, 32'hC170_0000);
        chkf(9'h019, 9'h008);
        run(32'h3F80_0000, 32'h4000_0000, 32'h0000_0007, 32'h3F80_0000);
        chkf(9'h019, 9'h018);
        chk({31'h0, busy_seen}, 32'h0);
        run(32'h3F80_0000, 32'h7FC0_0000, 32'h0000_0003, 32'h3F80_0000);
        chkf(9'h100, 9'h100);
        run(32'h7F7F_FFFF, 32'h7F7F_FFFF, 32'h0000_0003, 32'h7F80_0000);
        chkf(9'h060, 9'h060);
        run(32'h0080_0001, 32'h8080_0000, 32'h0000_0003, 32'h0000_0000);
        chkf(9'h081, 9'h081);
    endtask
    task automatic t_irq();
        bus(1'b1, BRA_ADDR_IRQ_STAT, 32'h0000_0003);
        bus(1'b1, BRA_ADDR_IRQ_MASK, 32'h0000_0001);
        chk_irq(1'b0);
        run(32'h0000_1111, 32'h0000_0001, 32'h0000_0009, 32'h0000_1111);
        chk_irq(1'b1);
        bus(1'b0, BRA_ADDR_IRQ_STAT, 32'h0);
        chk(rd_q, 32'h0000_0003);
        bus(1'b1, BRA_ADDR_IRQ_MASK, 32'h0000_0002);
        bus(1'b1, BRA_ADDR_IRQ_STAT, 32'h0000_0002);
        chk_irq(1'b0);
        bus(1'b0, BRA_ADDR_IRQ_STAT, 32'h0);
        chk(rd_q, 32'h0000_0001);
    endtask
    initial begin
        num_errors = 0;
        compares = 0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_bcd();
        t_real();
        t_irq();
        end_sim();
    end
endmodule
